// ===== gpc_debounce.sv
// Input debounce filter with edge pulses
`timescale 1ns/1ps
module gpc_debounce #(
    parameter logic [gpc_pkg::CNT_W-1:0] LIM_8 = gpc_pkg::CNT_W'(1),
    parameter logic [gpc_pkg::CNT_W-1:0] LIM_16 = gpc_pkg::CNT_W'(1),
    parameter logic [gpc_pkg::CNT_W-1:0] LIM_32 = gpc_pkg::CNT_W'(1)
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    gpc_filt_if.filt f
);
    logic [gpc_pkg::CNT_W-1:0] cnt_q;
    logic [gpc_pkg::CNT_W-1:0] lim;
    logic stable_q;
    logic rise_q;
    logic fall_q;
    logic accept;

    always_comb begin
        unique case (f.sel)
            gpc_pkg::FILT_8MS: lim = LIM_8;
            gpc_pkg::FILT_16MS: lim = LIM_16;
            default: lim = LIM_32;
        endcase
    end

    // A change is taken at once, or after it has held for the full time
    assign accept = (f.raw != stable_q) &&
        (f.sel == gpc_pkg::FILT_NONE || cnt_q >= lim - 1'b1);

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || f.raw == stable_q || accept) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            stable_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            if (accept) begin
                stable_q <= f.raw;
            end
            // Edges come from the filtered level only
            rise_q <= accept && f.raw;
            fall_q <= accept && !f.raw;
        end
    end

    assign f.level = stable_q;
    assign f.rise = rise_q;
    assign f.fall = fall_q;
    assign f.busy = (f.raw != stable_q);
endmodule // gpc_debounce

// ===== gpc_filt_if.sv
// Signals between the pin logic and its input filter
`timescale 1ns/1ps
interface gpc_filt_if;
    logic raw;
    logic [1:0] sel;
    logic level;
    logic rise;
    logic fall;
    logic busy;
    modport filt (input raw, input sel, output level, output rise,
        output fall, output busy);
    modport user (output raw, output sel, input level, input rise,
        input fall, input busy);
endinterface

// ===== gpc_pin_model.sv
// Far-side model of the pin: external driver, pulls and wire level
`timescale 1ns/1ps
module gpc_pin_model (
    input wire logic clk_sys_in,
    input wire logic ext_en_in,
    input wire logic ext_level_in,
    input wire logic pad_out_in,
    input wire logic pad_oe_in,
    input wire logic pullup_in,
    input wire logic pulldown_in,
    output logic pad_level_out
);
    logic float_q = 1'h0;
    // A floating pin wanders instead of keeping its last value
    always @(posedge clk_sys_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        if (pad_oe_in) begin
            pad_level_out = pad_out_in;
        end else if (ext_en_in) begin
            pad_level_out = ext_level_in;
        end else if (pullup_in) begin
            pad_level_out = 1'h1;
        end else if (pulldown_in) begin
            pad_level_out = 1'h0;
        end else begin
            pad_level_out = float_q;
        end
    end
endmodule // gpc_pin_model

// ===== gpc_pkg.sv
// Constants for the pin configuration block
package gpc_pkg;
    localparam int CLK_KHZ = 200_000;
    localparam int DBNC_8_MS = 8;
    localparam int DBNC_16_MS = 16;
    localparam int DBNC_32_MS = 32;
    localparam int DBNC_8_CYC = DBNC_8_MS * CLK_KHZ;
    localparam int DBNC_16_CYC = DBNC_16_MS * CLK_KHZ;
    localparam int DBNC_32_CYC = DBNC_32_MS * CLK_KHZ;
    localparam int CNT_W = 23;
    localparam int ADDR_W = 10;
    localparam logic [7:0] CFG_INDEX = 8'h73;
    localparam logic [7:0] STAT_INDEX = 8'h80;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int FILT_LSB = 6;
    localparam int EDGE_LSB = 4;
    localparam int OUT_BIT = 3;
    localparam int IN_BIT = 2;
    localparam int DIR_BIT = 1;
    localparam int DRV_BIT = 0;
    localparam int EDGE_FALL_BIT = 0;
    localparam int EDGE_RISE_BIT = 1;
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_8MS = 2'h1;
    localparam logic [1:0] FILT_16MS = 2'h2;
    localparam logic [1:0] EDGE_MASKED = 2'h0;
    localparam logic DIR_OUTPUT = 1'h0;
    localparam logic DRV_OPEN_DRAIN = 1'h0;
    localparam int STAT_LEVEL_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_INMODE_BIT = 2;
endpackage

// ===== gpc_top.sv
// Configuration, drive and input sensing for one general-purpose pin
// What this block does
// - input mode debounces both edges; 00 none, 01/10/11 = 8/16/32 ms
// - output mode ignores the input filter select
// - input mode interrupt: 00 masked, 01 falling, 10 rising, 11 both
// - output mode ignores edge select and raises no pin interrupt
// - output drives low for 0; for 1 drives high or releases
// - input mode: level bit 0 enables pull-up, 1 enables pull-down
// - input mode reads the pin level in the input level bit
// - input mode discards software writes to the input level bit
// - in output mode the input level bit has no effect
// - alternate off: direction 0 is output, 1 is input
// - alternate output is driven active high whatever else is set
// - output mode: drive bit 0 open-drain, 1 push-pull
`timescale 1ns/1ps
module gpc_top #(
    parameter int unsigned DBNC_8_CYC = gpc_pkg::DBNC_8_CYC,
    parameter int unsigned DBNC_16_CYC = gpc_pkg::DBNC_16_CYC,
    parameter int unsigned DBNC_32_CYC = gpc_pkg::DBNC_32_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [gpc_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_out,
    output logic pullup_enable_out,
    output logic pulldown_enable_out,
    input wire logic alt_function_enable_in,
    input wire logic alt_out_in,
    output logic edge_irq_out
);
    localparam logic [gpc_pkg::ADDR_W-1:0] CFG_ADDR =
        {gpc_pkg::CFG_INDEX, 2'b00};
    localparam logic [gpc_pkg::ADDR_W-1:0] STAT_ADDR =
        {gpc_pkg::STAT_INDEX, 2'b00};

    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic ack_q;
    logic req;
    logic take;
    logic cfg_wr;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic input_mode;
    logic [1:0] filter_sel;
    logic [1:0] edge_sel;
    logic out_level_bit;
    logic pin_direction_bit;
    logic drive_type_bit;
    logic in_level_shown;
    logic pad_out_q;
    logic pad_oe_q;
    logic pu_q;
    logic pd_q;
    logic irq_q;
    logic irq_d;
    logic drv_out;
    logic drv_oe;

    gpc_filt_if filt_bus ();

    // Field views of the configuration register
    assign filter_sel = cfg_q[gpc_pkg::FILT_LSB +: 2];
    assign edge_sel = cfg_q[gpc_pkg::EDGE_LSB +: 2];
    assign out_level_bit = cfg_q[gpc_pkg::OUT_BIT];
    assign pin_direction_bit = cfg_q[gpc_pkg::DIR_BIT];
    assign drive_type_bit = cfg_q[gpc_pkg::DRV_BIT];

    // Input mode needs direction 1 and the alternate function off
    assign input_mode = !alt_function_enable_in &&
        (pin_direction_bit != gpc_pkg::DIR_OUTPUT);

    // Bus slave: one wait cycle, answer on the second edge
    assign req = avs_read_in || avs_write_in;
    assign take = req && !ack_q;
    assign avs_waitrequest_out = req && !ack_q;
    // Write lands at the edge where the master sees waitrequest low
    assign cfg_wr = ack_q && avs_write_in && avs_address_in == CFG_ADDR &&
        avs_byteenable_in[0];

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // Stored input level bit keeps its old value while in input mode
    always_comb begin
        cfg_d = avs_writedata_in[7:0];
        if (input_mode) begin
            cfg_d[gpc_pkg::IN_BIT] = cfg_q[gpc_pkg::IN_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cfg_q <= gpc_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= cfg_d;
        end
    end

    // Input level bit reads the filtered pin while in input mode
    assign in_level_shown = input_mode ? filt_bus.level :
        cfg_q[gpc_pkg::IN_BIT];

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (avs_address_in == CFG_ADDR) begin
            rdata_d[7:0] = cfg_q;
            rdata_d[gpc_pkg::IN_BIT] = in_level_shown;
        end else if (avs_address_in == STAT_ADDR) begin
            rdata_d[gpc_pkg::STAT_LEVEL_BIT] = filt_bus.level;
            rdata_d[gpc_pkg::STAT_BUSY_BIT] = filt_bus.busy;
            rdata_d[gpc_pkg::STAT_INMODE_BIT] = input_mode;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (take && avs_read_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_out = rdata_q;

    // Input filter; select forced off when not sensing
    assign filt_bus.raw = pad_in;
    assign filt_bus.sel = input_mode ? filter_sel : gpc_pkg::FILT_NONE;

    gpc_debounce #(
        .LIM_8(gpc_pkg::CNT_W'(DBNC_8_CYC)),
        .LIM_16(gpc_pkg::CNT_W'(DBNC_16_CYC)),
        .LIM_32(gpc_pkg::CNT_W'(DBNC_32_CYC))
    ) u_debounce (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .f(filt_bus)
    );

    // Pin drive; the stored input level bit never reaches it
    always_comb begin
        drv_out = 1'b0;
        drv_oe = 1'b0;
        if (alt_function_enable_in) begin
            drv_out = alt_out_in;
            drv_oe = 1'b1;
        end else if (!input_mode) begin
            if (!out_level_bit) begin
                drv_oe = 1'b1;
            end else begin
                drv_out = 1'b1;
                drv_oe = drive_type_bit != gpc_pkg::DRV_OPEN_DRAIN;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
        end else begin
            pad_out_q <= drv_out;
            pad_oe_q <= drv_oe;
        end
    end

    // Pulls only in input mode, chosen by the output level bit
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pu_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            pu_q <= input_mode && !out_level_bit;
            pd_q <= input_mode && out_level_bit;
        end
    end

    // Edge interrupt pulse from filtered edges, only in input mode
    always_comb begin
        irq_d = 1'b0;
        if (input_mode) begin
            irq_d = (edge_sel[gpc_pkg::EDGE_FALL_BIT] && filt_bus.fall) ||
                (edge_sel[gpc_pkg::EDGE_RISE_BIT] && filt_bus.rise);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign pad_out = pad_out_q;
    assign pad_oe_out = pad_oe_q;
    assign pullup_enable_out = pu_q;
    assign pulldown_enable_out = pd_q;
    assign edge_irq_out = irq_q;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    // Unfiltered input follows the pin within two edges
    AST_NO_FILTER_PASS: assert property (
        (input_mode && filter_sel == gpc_pkg::FILT_NONE &&
            pad_in != filt_bus.level) ##1
        (input_mode && filter_sel == gpc_pkg::FILT_NONE &&
            $stable(pad_in))
        |-> filt_bus.level == pad_in)
        else $error("unfiltered level did not follow pin");

    // A filtered change is not taken at its first cycle
    AST_FILTER_HOLDS: assert property (
        (input_mode && filter_sel != gpc_pkg::FILT_NONE &&
            $changed(pad_in) && !$past(filt_bus.busy))
        |=> $stable(filt_bus.level))
        else $error("filtered level changed at once");

    // Output mode never raises the pin interrupt
    AST_OUTPUT_NO_IRQ: assert property (
        !input_mode |=> !edge_irq_out)
        else $error("interrupt raised in output mode");

    // Masked edge select never raises the interrupt
    AST_MASKED_NO_IRQ: assert property (
        edge_sel == gpc_pkg::EDGE_MASKED |=> !edge_irq_out)
        else $error("masked interrupt raised");

    // Enabled rising edge reaches the interrupt next cycle
    AST_RISE_IRQ: assert property (
        input_mode && edge_sel[gpc_pkg::EDGE_RISE_BIT] && filt_bus.rise
        |=> edge_irq_out)
        else $error("rising edge interrupt missing");

    // Interrupt only follows a filtered edge
    AST_IRQ_CAUSE: assert property (
        edge_irq_out |-> $past(filt_bus.rise || filt_bus.fall))
        else $error("interrupt without filtered edge");

    // Pull selection follows the output level bit
    AST_PULLS: assert property (
        input_mode ##1 $stable(cfg_q) |-> pullup_enable_out ==
            !out_level_bit && pulldown_enable_out == out_level_bit)
        else $error("pull selection wrong in input mode");

    // Open-drain high releases the pin
    AST_OPEN_DRAIN: assert property (
        !input_mode && !alt_function_enable_in && out_level_bit &&
        drive_type_bit == gpc_pkg::DRV_OPEN_DRAIN |=> !pad_oe_out)
        else $error("open-drain high still drives");

    // Output low is driven in output mode with the alternate function off
    AST_DRIVE_LOW: assert property (
        !input_mode && !alt_function_enable_in && !out_level_bit
        |=> pad_oe_out && !pad_out)
        else $error("output low not driven");

    // Alternate output passes straight to the pin
    AST_ALT_OUT: assert property (
        alt_function_enable_in |=> pad_oe_out && pad_out == $past(alt_out_in))
        else $error("alternate output not driven active high");

    // Writes to the input level bit are dropped in input mode
    AST_IN_BIT_RO: assert property (
        cfg_wr && input_mode |=> cfg_q[gpc_pkg::IN_BIT] ==
            $past(cfg_q[gpc_pkg::IN_BIT]))
        else $error("input level bit written in input mode");

    // Every request is answered after one wait cycle
    AST_BUS_ANSWER: assert property (
        take |=> !avs_waitrequest_out)
        else $error("bus request not answered");

    // Enabled falling edge reaches the interrupt next cycle
    AST_FALL_IRQ: assert property (
        input_mode && edge_sel[gpc_pkg::EDGE_FALL_BIT] && filt_bus.fall
        |=> edge_irq_out)
        else $error("falling edge interrupt missing");

    // Input mode leaves the pin undriven
    AST_INPUT_RELEASED: assert property (
        input_mode |=> !pad_oe_out)
        else $error("pin driven in input mode");

    // Pulls stay off outside input mode
    AST_NO_PULL_OUT: assert property (
        !input_mode |=> !pullup_enable_out && !pulldown_enable_out)
        else $error("pull enabled outside input mode");

    // Push-pull high drives the pin high
    AST_PUSH_PULL_HIGH: assert property (
        !input_mode && !alt_function_enable_in && out_level_bit &&
        drive_type_bit != gpc_pkg::DRV_OPEN_DRAIN |=> pad_oe_out && pad_out)
        else $error("push-pull high not driven");
endmodule // gpc_top

// ===== gpio3_pin_config_bench.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
module gpio3_pin_config_bench;
    localparam logic [9:0] CFG_A = 10'h1CC;
    localparam logic [9:0] STAT_A = 10'h200;
    logic clk_sys_in = 1'h0;
    logic reset_in = 1'h1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pad_in, pad_out, pad_oe_out, pullup_out, pulldown_out;
    logic alt_en = 1'h0;
    logic alt_out = 1'h0;
    logic edge_irq_out;
    logic ext_en = 1'h0;
    logic ext_level = 1'h0;
    logic [31:0] rdata;
    int irq_cnt = 0;
    int num_errors = 0;
    int n_checks = 0;
    int lim [4] = '{0, 4, 8, 16};

    always #2.5 clk_sys_in = ~clk_sys_in;

    gpc_top #(.DBNC_8_CYC(4), .DBNC_16_CYC(8), .DBNC_32_CYC(16)) i_dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_out(pad_oe_out),
        .pullup_enable_out(pullup_out), .pulldown_enable_out(pulldown_out),
        .alt_function_enable_in(alt_en), .alt_out_in(alt_out),
        .edge_irq_out(edge_irq_out)
    );

    gpc_pin_model i_pin (
        .clk_sys_in(clk_sys_in), .ext_en_in(ext_en),
        .ext_level_in(ext_level), .pad_out_in(pad_out),
        .pad_oe_in(pad_oe_out), .pullup_in(pullup_out),
        .pulldown_in(pulldown_out), .pad_level_out(pad_in)
    );

    // Pulse counter, sampled away from the launching edge
    always @(negedge clk_sys_in) begin
        if (edge_irq_out === 1'h1) begin
            irq_cnt++;
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int i;
        @(posedge clk_sys_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_in);
            if (avs_waitrequest === 1'h0) break;
        end
        if (i == 20) begin
            num_errors++;
            $display("ERROR bus wait expected done seen stuck");
            end_of_test();
        end
        rdata = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask

    task automatic cfg(input logic [7:0] d);
        bus(1'h1, CFG_A, {24'h0, d}, 4'hF);
    endtask

    task automatic rd(input logic [9:0] a);
        bus(1'h0, a, 32'h0, 4'hF);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    initial begin
        cyc(12);
        reset_in <= 1'h0;
        cyc(3);
        chk("oe after reset", 32'h1, 32'(pad_oe_out));
        chk("pad after reset", 32'h0, 32'(pad_out));
        rd(CFG_A);
        chk("config reset", 32'h0, rdata);
        bus(1'h1, 10'h004, 32'hFF, 4'hF);
        rd(10'h004);
        chk("unmapped read", 32'h0, rdata);
        bus(1'h1, CFG_A, 32'h0F, 4'h0);
        rd(CFG_A);
        chk("lane off write", 32'h0, rdata);
        // Output mode: every level, drive type and input bit value
        for (int k = 0; k < 8; k++) begin
            cfg({4'hF, k[1], k[2], 1'h0, k[0]});
            cyc(3);
            chk("out oe", 32'(!(k[1] && !k[0])), 32'(pad_oe_out));
            if (k[0] || !k[1]) begin
                chk("out level", 32'(k[1]), 32'(pad_out));
            end
            rd(CFG_A);
            chk("out readback", {24'h0, 4'hF, k[1], k[2], 1'h0, k[0]}, rdata);
        end
        // Released output, outside party toggles faster than the filter
        cfg(8'hF8);
        ext_en <= 1'h1;
        cyc(3);
        irq_cnt = 0;
        for (int k = 0; k < 4; k++) begin
            ext_level <= ~ext_level;
            cyc(3);
        end
        ext_level <= 1'h1;
        cyc(3);
        chk("output irq", 32'h0, 32'(irq_cnt));
        rd(STAT_A);
        chk("output unfiltered", 32'h1, rdata & 32'h5);
        // Input mode pulls and tristate
        for (int k = 0; k < 4; k++) begin
            cfg({4'h0, k[1], 1'h0, 1'h1, k[0]});
            cyc(3);
            chk("in oe", 32'h0, 32'(pad_oe_out));
            chk("pull-up", 32'(!k[1]), 32'(pullup_out));
            chk("pull-down", 32'(k[1]), 32'(pulldown_out));
        end
        cfg(8'h02);
        cyc(3);
        rd(CFG_A);
        chk("in level high", 32'h06, rdata);
        ext_level <= 1'h0;
        cyc(3);
        cfg(8'h06);
        rd(CFG_A);
        chk("in bit write", 32'h02, rdata);
        // Alternate mode shows the stored bit, which must not have changed
        alt_en <= 1'h1;
        rd(CFG_A);
        chk("in bit kept", 32'h02, rdata);
        alt_en <= 1'h0;
        // Every edge select, no filtering
        for (int s = 0; s < 4; s++) begin
            cfg({2'h0, s[1:0], 4'h2});
            cyc(4);
            irq_cnt = 0;
            ext_level <= 1'h1;
            cyc(5);
            chk("rise irq", 32'(s[1]), 32'(irq_cnt));
            irq_cnt = 0;
            ext_level <= 1'h0;
            cyc(5);
            chk("fall irq", 32'(s[0]), 32'(irq_cnt));
        end
        // Every filter time: short glitch, then a held change
        for (int f = 1; f < 4; f++) begin
            cfg({f[1:0], 2'h3, 4'h2});
            cyc(lim[f] + 4);
            irq_cnt = 0;
            ext_level <= 1'h1;
            cyc(lim[f] - 2);
            ext_level <= 1'h0;
            cyc(lim[f] + 4);
            chk("glitch irq", 32'h0, 32'(irq_cnt));
            rd(STAT_A);
            chk("glitch level", 32'h4, rdata & 32'h5);
            ext_level <= 1'h1;
            cyc(lim[f] - 2);
            chk("early irq", 32'h0, 32'(irq_cnt));
            cyc(8);
            chk("held irq", 32'h1, 32'(irq_cnt));
            ext_level <= 1'h0;
            cyc(lim[f] + 6);
        end
        // Alternate output over an open-drain high setting
        ext_en <= 1'h0;
        cfg(8'h08);
        alt_en <= 1'h1;
        for (int v = 0; v < 2; v++) begin
            alt_out <= v[0];
            cyc(3);
            chk("alt oe", 32'h1, 32'(pad_oe_out));
            chk("alt level", 32'(v[0]), 32'(pad_out));
        end
        alt_en <= 1'h0;
        cyc(3);
        end_of_test();
    end
endmodule // gpio3_pin_config_bench
